// [src/mdc_pkg.sv]
package mdc_pkg;

  localparam int NCH = 14;
  localparam int CHW = 4;

  // Request line positions of the bound peripherals.
  localparam int CH_FIRST_SERIAL_TX      = 0;
  localparam int CH_FIRST_SERIAL_RX      = 1;
  localparam int CH_SECOND_SERIAL_TX     = 2;
  localparam int CH_SECOND_SERIAL_RX     = 3;
  localparam int CH_UART_TX              = 4;
  localparam int CH_UART_RX              = 5;
  localparam int CH_FIRST_TWO_WIRE_STX   = 6;
  localparam int CH_FIRST_TWO_WIRE_SRX   = 7;
  localparam int CH_FIRST_TWO_WIRE_MST   = 8;
  localparam int CH_SECOND_TWO_WIRE_STX  = 9;
  localparam int CH_SECOND_TWO_WIRE_SRX  = 10;
  localparam int CH_SECOND_TWO_WIRE_MST  = 11;
  localparam int CH_CONVERTER            = 12;
  localparam int CH_FLASH                = 13;

  // Control structure layout in SRAM.
  localparam logic [31:0] OFS_SRC_END   = 32'h0000_0000;
  localparam logic [31:0] OFS_DST_END   = 32'h0000_0004;
  localparam logic [31:0] OFS_CTRL      = 32'h0000_0008;
  localparam logic [31:0] STRUCT_STRIDE = 32'h0000_0010;
  localparam logic [31:0] ALT_OFS       = 32'h0000_0100;
  localparam logic [1:0]  WIDX_CTRL     = 2'h2;

  // Register byte offsets.
  localparam logic [7:0] REG_CFG      = 8'h00;
  localparam logic [7:0] REG_BASE     = 8'h04;
  localparam logic [7:0] REG_PRI_SET  = 8'h08;
  localparam logic [7:0] REG_PRI_CLR  = 8'h0c;
  localparam logic [7:0] REG_SW_REQ   = 8'h10;
  localparam logic [7:0] REG_EN_SET   = 8'h14;
  localparam logic [7:0] REG_EN_CLR   = 8'h18;
  localparam logic [7:0] REG_ALT      = 8'h1c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h24;
  localparam logic [7:0] REG_IRQ_EN   = 8'h28;
  localparam logic [7:0] REG_STATUS   = 8'h2c;

  localparam logic [2:0] CYC_STOP     = 3'h0;
  localparam logic [2:0] CYC_PINGPONG = 3'h3;
  localparam logic [1:0] INC_NONE     = 2'h3;

  typedef struct packed {
    logic [1:0] dst_inc;
    logic [1:0] dst_size;
    logic [1:0] src_inc;
    logic [1:0] src_size;
    logic [5:0] rsvd;
    logic [3:0] r_power;
    logic [9:0] n_minus_1;
    logic       next_burst;
    logic [2:0] cycle;
  } mdc_ctrl_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        rd;
    logic        wr;
    logic [3:0]  be;
  } mdc_mreq_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_FETCH = 6'h02,
    ST_RD    = 6'h04,
    ST_WR    = 6'h08,
    ST_WB    = 6'h10,
    ST_DONE  = 6'h20
  } mdc_state_t;

  // Byte lanes of one element of the given size at the given address.
  function automatic logic [3:0] mdc_lanes(input logic [1:0] size, input logic [1:0] a);
    logic [3:0] m;
    m = (size == 2'h0) ? 4'h1 : (size == 2'h1) ? 4'h3 : 4'hf;
    return 4'((m << a));
  endfunction

  // Merge bus write data into a register under byte enables.
  function automatic logic [31:0] mdc_bemerge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

endpackage

// [src/mdc_arb.sv]
`timescale 1ns/100ps
module mdc_arb
  import mdc_pkg::*;
(
  input  wire logic [NCH-1:0] req,
  input  wire logic [NCH-1:0] pri_hi,
  output logic                gnt_valid,
  output logic [CHW-1:0]      gnt_idx
);
  wire logic [NCH-1:0] hi_req;
  wire logic [NCH-1:0] pool;
  wire logic [NCH-1:0] onehot;
  wire logic [CHW-1:0] idx_bits [NCH];

  assign hi_req    = req & pri_hi;
  assign pool      = (|hi_req) ? hi_req : req;
  assign onehot    = pool & (~pool + 14'h0001);
  assign gnt_valid = |req;

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_enc
      if (g == 0)
      begin : g_first
        assign idx_bits[g] = '0;
      end
      else
      begin : g_rest
        assign idx_bits[g] = idx_bits[g-1] | (onehot[g] ? CHW'(g) : '0);
      end
    end
  endgenerate

  assign gnt_idx = idx_bits[NCH-1];
endmodule // mdc_arb

// [src/mdc_irq.sv]
`timescale 1ns/100ps
module mdc_irq
  import mdc_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic [NCH-1:0] ev_set,
  input  wire logic           clr_wr,
  input  wire logic           en_wr,
  input  wire logic [NCH-1:0] wdata,
  output logic      [NCH-1:0] stat_r,
  output logic      [NCH-1:0] en_r,
  output logic                irq
);
  wire logic [NCH-1:0] stat_nxt;

  // A completion in the same cycle as its clear is kept.
  assign stat_nxt = ev_set | (stat_r & ~(clr_wr ? wdata : '0));
  assign irq      = |(stat_r & en_r);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stat_r <= '0;
      en_r   <= '0;
    end
    else
    begin
      stat_r <= stat_nxt;
      if (en_wr)
        en_r <= wdata;
    end
  end
endmodule // mdc_irq

// [src/mdc_dma.sv]
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
// What this block does
// - Fourteen independent channels, one per peripheral request function.
// - Request line order: serial, serial, UART, two-wire, two-wire, converter, flash.
// - Each channel starts on its hardware request line or a software trigger.
// - High-level requesting channels win over all default-level channels.
// - Within a level the lowest channel number wins.
// - Software raises a channel's level through the priority raise register.
// - Byte, half word and word elements, set separately for source and destination.
// - Peripheral, flash or SRAM may be source or destination in any pairing.
// - Controller is a system bus master and may stall other bus users.
// - Finishing all programmed transfers raises that channel's own completion interrupt.
// - The channel's control structure is read from SRAM before data moves.
// - Each channel owns primary and alternate structures; ping-pong uses both.
// - Structure words: source end, destination end, control, reserved.
// - Pointer words hold the last addresses of the data, not the first.
// - Control word gives sizes, transfer count and transfers per arbitration.
// - Primary at base plus channel times 0x010; alternate 0x100 higher.
module mdc_dma
  import mdc_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic [7:0]     avs_address,
  input  wire logic           avs_read,
  input  wire logic           avs_write,
  input  wire logic [31:0]    avs_writedata,
  input  wire logic [3:0]     avs_byteenable,
  output logic      [31:0]    avs_readdata,
  output logic                avs_waitrequest,
  output logic      [31:0]    dm_address,
  output logic                dm_read,
  output logic                dm_write,
  output logic      [31:0]    dm_writedata,
  output logic      [3:0]     dm_byteenable,
  input  wire logic [31:0]    dm_readdata,
  input  wire logic           dm_waitrequest,
  input  wire logic [NCH-1:0] chan_req_hw,
  output logic      [NCH-1:0] chan_done,
  output logic                irq
);

  // Register slave.
  logic                ack_r;
  logic [31:0]         rdata_r;
  logic                cfg_en_r;
  logic [31:0]         descriptor_base_pointer;
  logic [NCH-1:0]      pri_hi_r;
  logic [NCH-1:0]      sw_req_r;
  logic [NCH-1:0]      chan_en_r;
  logic [NCH-1:0]      alt_sel_r;
  wire logic           wr_acc;
  wire logic [NCH-1:0] wd_ch;
  wire logic           wr_cfg;
  wire logic           wr_base;
  wire logic           wr_pri_set;
  wire logic           wr_pri_clr;
  wire logic           wr_sw;
  wire logic           wr_en_set;
  wire logic           wr_en_clr;
  wire logic           wr_irq_clr;
  wire logic           wr_irq_en;
  wire logic [NCH-1:0] irq_stat;
  wire logic [NCH-1:0] irq_en;
  logic      [31:0]    rd_mux;

  // Engine.
  mdc_state_t          state_r;
  logic [CHW-1:0]      chan_r;
  logic                alt_r;
  logic [1:0]          widx_r;
  logic [31:0]         src_end_r;
  logic [31:0]         dst_end_r;
  mdc_ctrl_t           ctrl_r;
  logic [10:0]         burst_r;
  logic                last_r;
  logic                pp_r;
  logic [31:0]         data_r;
  wire logic [NCH-1:0] pend;
  wire logic           gnt_valid;
  wire logic [CHW-1:0] gnt_idx;
  wire logic [31:0]    struct_base;
  wire logic [31:0]    src_addr;
  wire logic [31:0]    dst_addr;
  wire logic [31:0]    rd_aligned;
  wire logic           bus_ok;
  wire logic           last_xfer;
  wire logic [NCH-1:0] chan_bit;
  wire logic [NCH-1:0] done_set;
  mdc_mreq_t           mreq;

  // One wait cycle on every access keeps read data registered.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = rdata_r;
  assign wr_acc          = avs_write & ack_r;
  assign wd_ch           = avs_writedata[NCH-1:0];

  assign wr_cfg     = wr_acc && (avs_address == REG_CFG);
  assign wr_base    = wr_acc && (avs_address == REG_BASE);
  assign wr_pri_set = wr_acc && (avs_address == REG_PRI_SET);
  assign wr_pri_clr = wr_acc && (avs_address == REG_PRI_CLR);
  assign wr_sw      = wr_acc && (avs_address == REG_SW_REQ);
  assign wr_en_set  = wr_acc && (avs_address == REG_EN_SET);
  assign wr_en_clr  = wr_acc && (avs_address == REG_EN_CLR);
  assign wr_irq_clr = wr_acc && (avs_address == REG_IRQ_CLR);
  assign wr_irq_en  = wr_acc && (avs_address == REG_IRQ_EN);

  always_comb
  begin
    case (avs_address)
      REG_CFG:      rd_mux = {31'h0, cfg_en_r};
      REG_BASE:     rd_mux = descriptor_base_pointer;
      REG_PRI_SET:  rd_mux = {18'h0, pri_hi_r};
      REG_SW_REQ:   rd_mux = {18'h0, sw_req_r};
      REG_EN_SET:   rd_mux = {18'h0, chan_en_r};
      REG_ALT:      rd_mux = {18'h0, alt_sel_r};
      REG_IRQ_STAT: rd_mux = {18'h0, irq_stat};
      REG_IRQ_EN:   rd_mux = {18'h0, irq_en};
      REG_STATUS:   rd_mux = {26'h0, chan_r, 1'b0, ~state_r[0]};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (avs_read & ~ack_r)
        rdata_r <= rd_mux;
    end
  end

  assign chan_bit = NCH'(1) << chan_r;
  assign done_set = (state_r == ST_DONE) ? chan_bit : '0;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_en_r                <= 1'b0;
      descriptor_base_pointer <= 32'h0000_0000;
      pri_hi_r                <= '0;
    end
    else
    begin
      if (wr_cfg)
        cfg_en_r <= avs_writedata[0];
      if (wr_base)
        descriptor_base_pointer <= mdc_bemerge(descriptor_base_pointer, avs_writedata, avs_byteenable);
      if (wr_pri_set | wr_pri_clr)
        pri_hi_r <= wr_pri_set ? (pri_hi_r | wd_ch) : (pri_hi_r & ~wd_ch);
    end
  end

  // A software trigger stays pending until its channel completes; a new trigger in that
  // same cycle survives the clear.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sw_req_r  <= '0;
      chan_en_r <= '0;
      alt_sel_r <= '0;
    end
    else
    begin
      sw_req_r <= (sw_req_r & ~done_set) | (wr_sw ? wd_ch : '0);
      chan_en_r <= ((chan_en_r & ~(wr_en_clr ? wd_ch : '0)) & ~(pp_r ? '0 : done_set))
                   | (wr_en_set ? wd_ch : '0);
      if (pp_r)
        alt_sel_r <= alt_sel_r ^ done_set;
    end
  end

  mdc_irq u_irq (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ev_set  (done_set),
    .clr_wr  (wr_irq_clr),
    .en_wr   (wr_irq_en),
    .wdata   (wd_ch),
    .stat_r  (irq_stat),
    .en_r    (irq_en),
    .irq     (irq)
  );

  // Peripherals hold their request line while they need service.
  assign pend = chan_en_r & (chan_req_hw | sw_req_r);

  mdc_arb u_arb (
    .req       (pend),
    .pri_hi    (pri_hi_r),
    .gnt_valid (gnt_valid),
    .gnt_idx   (gnt_idx)
  );

  assign struct_base = descriptor_base_pointer
                       + 32'(32'(chan_r) * STRUCT_STRIDE)
                       + (alt_r ? ALT_OFS : 32'h0000_0000);

  // Addresses count up toward the end pointers; the remaining count says how far back.
  assign src_addr = (ctrl_r.src_inc == INC_NONE) ? src_end_r
                    : src_end_r - 32'(({22'h0, ctrl_r.n_minus_1} << ctrl_r.src_inc));
  assign dst_addr = (ctrl_r.dst_inc == INC_NONE) ? dst_end_r
                    : dst_end_r - 32'(({22'h0, ctrl_r.n_minus_1} << ctrl_r.dst_inc));

  // Lane steering assumes aligned elements; a misaligned pointer moves the wrong bytes.
  assign rd_aligned = dm_readdata >> {src_addr[1:0], 3'b000};

  assign bus_ok    = ~dm_waitrequest;
  assign last_xfer = (ctrl_r.n_minus_1 == 10'h000);

  always_comb
  begin
    mreq = '0;
    case (state_r)
      ST_FETCH:
      begin
        mreq.addr = struct_base + {28'h0, widx_r, 2'b00};
        mreq.rd   = 1'b1;
        mreq.be   = 4'hf;
      end
      ST_RD:
      begin
        mreq.addr = {src_addr[31:2], 2'b00};
        mreq.rd   = 1'b1;
        mreq.be   = mdc_lanes(ctrl_r.src_size, src_addr[1:0]);
      end
      ST_WR:
      begin
        mreq.addr = {dst_addr[31:2], 2'b00};
        mreq.wr   = 1'b1;
        mreq.be   = mdc_lanes(ctrl_r.dst_size, dst_addr[1:0]);
      end
      ST_WB:
      begin
        mreq.addr = struct_base + OFS_CTRL;
        mreq.wr   = 1'b1;
        mreq.be   = 4'hf;
      end
      default:
      begin
        mreq = '0;
      end
    endcase
  end

  // The request is held until the bus drops waitrequest, so other masters may stall us.
  assign dm_address    = mreq.addr;
  assign dm_read       = mreq.rd;
  assign dm_write      = mreq.wr;
  assign dm_byteenable = mreq.be;
  assign dm_writedata  = (state_r == ST_WB) ? ctrl_r : data_r;
  assign chan_done     = done_set;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r   <= ST_IDLE;
      chan_r    <= '0;
      alt_r     <= 1'b0;
      widx_r    <= 2'h0;
      src_end_r <= 32'h0000_0000;
      dst_end_r <= 32'h0000_0000;
      ctrl_r    <= '0;
      burst_r   <= 11'h000;
      last_r    <= 1'b0;
      pp_r      <= 1'b0;
      data_r    <= 32'h0000_0000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          pp_r <= 1'b0;
          if (cfg_en_r && gnt_valid)
          begin
            chan_r  <= gnt_idx;
            alt_r   <= alt_sel_r[gnt_idx];
            widx_r  <= 2'h0;
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH:
        begin
          if (bus_ok)
          begin
            widx_r <= widx_r + 2'h1;
            case (widx_r)
              2'h0:    src_end_r <= dm_readdata;
              2'h1:    dst_end_r <= dm_readdata;
              default: ctrl_r    <= dm_readdata;
            endcase
            if (widx_r == WIDX_CTRL)
            begin
              burst_r <= 11'((11'h001 << dm_readdata[17:14]) - 11'h001);
              pp_r    <= (dm_readdata[2:0] == CYC_PINGPONG);
              // A stopped structure ends the channel without moving data.
              state_r <= (dm_readdata[2:0] == CYC_STOP) ? ST_DONE : ST_RD;
              last_r  <= (dm_readdata[2:0] == CYC_STOP);
            end
          end
        end
        ST_RD:
        begin
          if (bus_ok)
          begin
            data_r  <= 32'((rd_aligned << {dst_addr[1:0], 3'b000}));
            state_r <= ST_WR;
          end
        end
        ST_WR:
        begin
          if (bus_ok)
          begin
            last_r <= last_xfer;
            if (last_xfer)
              ctrl_r.cycle <= CYC_STOP;
            else
              ctrl_r.n_minus_1 <= ctrl_r.n_minus_1 - 10'h001;
            burst_r <= burst_r - 11'h001;
            // Re-arbitrate after the programmed number of transfers.
            state_r <= (last_xfer || burst_r == 11'h000) ? ST_WB : ST_RD;
          end
        end
        ST_WB:
        begin
          if (bus_ok)
            state_r <= last_r ? ST_DONE : ST_IDLE;
        end
        ST_DONE:
        begin
          state_r <= ST_IDLE;
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // mdc_dma

// [test/mdc_mem.sv]
`timescale 1ns/100ps
module mdc_mem
  import mdc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [31:0] dm_address,
  input  wire logic        dm_read,
  input  wire logic        dm_write,
  input  wire logic [31:0] dm_writedata,
  input  wire logic [3:0]  dm_byteenable,
  output logic      [31:0] dm_readdata,
  output logic             dm_waitrequest
);
  logic [31:0] mem [512];
  logic [1:0]  cnt_r = 2'h0;
  wire  [8:0]  idx = dm_address[10:2];
  wire         req = dm_read | dm_write;
  // Slow mode stalls every access two cycles, as a port shared with the processor would.
  assign dm_waitrequest = req & slow & (cnt_r != 2'h2);
  // Outside the data phase the lines carry inverted data, so stale values are never trusted.
  assign dm_readdata = (dm_read & ~dm_waitrequest) ? mem[idx] : ~mem[idx];
  always @(posedge clk)
  begin
    cnt_r <= (req & dm_waitrequest) ? cnt_r + 2'h1 : 2'h0;
    for (int i = 0; i < 4; i++)
      if (dm_write & ~dm_waitrequest & dm_byteenable[i])
        mem[idx][i*8 +: 8] <= dm_writedata[i*8 +: 8];
  end
endmodule // mdc_mem

// [test/mdc_dma_assertions.sv]
`timescale 1ns/100ps
module mdc_dma_assertions
  import mdc_pkg::*;
(
  input wire logic           clk,
  input wire logic           sys_rst,
  input wire logic [7:0]     avs_address,
  input wire logic           avs_read,
  input wire logic           avs_write,
  input wire logic [31:0]    avs_writedata,
  input wire logic           avs_waitrequest,
  input wire logic [31:0]    dm_address,
  input wire logic           dm_read,
  input wire logic           dm_write,
  input wire logic [3:0]     dm_byteenable,
  input wire logic           dm_waitrequest,
  input wire logic [NCH-1:0] chan_done,
  input wire logic           irq
);
  logic [31:0]    base_r;
  logic [31:0]    first_r;
  logic [NCH-1:0] ien_r;
  logic [1:0]     nx_r;
  wire            wr_ok = avs_write & ~avs_waitrequest;
  wire            mreq  = dm_read | dm_write;
  wire            mdone = mreq & ~dm_waitrequest;
  wire [31:0]     rel   = dm_address - base_r;
  // Counts finished master accesses since the bus last went quiet, saturating at three.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      base_r  <= 32'h0;
      first_r <= 32'h0;
      ien_r   <= '0;
      nx_r    <= 2'h0;
    end
    else
    begin
      base_r  <= (wr_ok && avs_address == REG_BASE) ? avs_writedata : base_r;
      ien_r   <= (wr_ok && avs_address == REG_IRQ_EN) ? avs_writedata[NCH-1:0] : ien_r;
      nx_r    <= !mreq ? 2'h0 : (mdone && nx_r != 2'h3) ? nx_r + 2'h1 : nx_r;
      first_r <= (mdone && nx_r == 2'h0) ? dm_address : first_r;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_fetch0;
    mreq && nx_r == 2'h0 |-> dm_read && rel[3:0] == 4'h0 && rel[31:9] == '0 && rel[7:4] <= 4'hd;
  endproperty
  a_fetch0: assert property (p_fetch0) else $error("first access is not a structure read");
  property p_fetch1;
    mreq && nx_r == 2'h1 |-> dm_read && dm_address == first_r + 32'h4;
  endproperty
  a_fetch1: assert property (p_fetch1) else $error("second fetch not at plus 4");
  property p_fetch2;
    mreq && nx_r == 2'h2 |-> dm_read && dm_address == first_r + 32'h8;
  endproperty
  a_fetch2: assert property (p_fetch2) else $error("control fetch not at plus 8");
  property p_hold;
    mreq && dm_waitrequest |=> $stable(dm_address) && $stable(dm_read) && $stable(dm_write);
  endproperty
  a_hold: assert property (p_hold) else $error("master request changed while stalled");
  property p_lanes;
    mreq |-> !(dm_read && dm_write) && dm_address[1:0] == 2'h0 &&
             dm_byteenable inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
  endproperty
  a_lanes: assert property (p_lanes) else $error("bad master lanes or direction");
  property p_onehot;
    $onehot0(chan_done);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two channels completed at once");
  property p_done_irq;
    (chan_done & ien_r) != '0 |=> irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("enabled completion gave no interrupt");
  property p_irq_mask;
    ien_r == '0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt high while all masked");
  property p_avs_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_avs_wait: assert property (p_avs_wait) else $error("register access stalled twice");
  c_done: cover property (chan_done != '0 && ien_r != '0);
  c_stall: cover property (mreq && dm_waitrequest);
  c_wb: cover property (nx_r == 2'h3 && dm_write);
endmodule // mdc_dma_assertions
bind mdc_dma mdc_dma_assertions i_mdc_dma_assertions (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_waitrequest, .dm_address, .dm_read, .dm_write, .dm_byteenable, .dm_waitrequest,
  .chan_done, .irq);

// [test/tb_top.sv]
`timescale 1ns/100ps
module tb_top
  import mdc_pkg::*;
;
  localparam logic [31:0] BASE = 32'h0000_0400;
  logic           clk = 1'b0;
  logic           sys_rst = 1'b1;
  logic           slow = 1'b1;
  logic [7:0]     avs_address = 8'h00;
  logic           avs_read = 1'b0;
  logic           avs_write = 1'b0;
  logic [31:0]    avs_writedata = 32'h0;
  logic [NCH-1:0] chan_req_hw = '0;
  logic [3:0]     avs_byteenable = 4'hf;
  logic [31:0]    avs_readdata, dm_address, dm_writedata, dm_readdata, q;
  logic           avs_waitrequest, dm_read, dm_write, dm_waitrequest, irq;
  logic [3:0]     dm_byteenable;
  logic [NCH-1:0] chan_done;
  int             errors = 0;
  int             total_checks = 0;
  int             order[$];
  always #25 clk = ~clk;
  mdc_dma i_mdc_dma (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .dm_address, .dm_read, .dm_write,
    .dm_writedata, .dm_byteenable, .dm_readdata, .dm_waitrequest, .chan_req_hw, .chan_done, .irq);
  mdc_mem i_mdc_mem (.clk, .slow, .dm_address, .dm_read, .dm_write, .dm_writedata, .dm_byteenable,
    .dm_readdata, .dm_waitrequest);
  always @(posedge clk)
    for (int i = 0; i < NCH; i++)
      if (chan_done[i] === 1'b1)
        order.push_back(i);
  function automatic mdc_ctrl_t ctl(input logic [1:0] sz, input logic [9:0] n, input logic [3:0] rp);
    return '{dst_inc:sz, dst_size:sz, src_inc:sz, src_size:sz, rsvd:6'h0, r_power:rp, n_minus_1:n,
             next_burst:1'b0, cycle:3'h1};
  endfunction
  function automatic logic [31:0] mr(input logic [31:0] a);
    return i_mdc_mem.mem[a[10:2]];
  endfunction
  task automatic mw(input logic [31:0] a, input logic [31:0] d);
    i_mdc_mem.mem[a[10:2]] = d;
  endtask
  task automatic dsc(input int ch, input logic [31:0] s, input logic [31:0] d, input mdc_ctrl_t c);
    mw(BASE + 32'(ch) * 32'h10, s);
    mw(BASE + 32'(ch) * 32'h10 + 32'h4, d);
    mw(BASE + 32'(ch) * 32'h10 + 32'h8, c);
    mw(BASE + 32'(ch) * 32'h10 + 32'hc, 32'h0);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Starts one edge late so a release and the next request never share a time step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wdone(input int n);
    while (order.size() < n)
      @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #2_000_000;
    errors++;
    end_sim();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(REG_IRQ_STAT, 32'h0);
    rdc(8'h40, 32'h0);
    rdc(REG_PRI_SET, 32'h0);
    wr(REG_CFG, 32'h1);
    wr(REG_BASE, BASE);
    rdc(REG_BASE, BASE);
    // Only the second byte lane may change the pointer here.
    avs_byteenable <= 4'h2;
    wr(REG_BASE, 32'hffff_ffff);
    avs_byteenable <= 4'hf;
    rdc(REG_BASE, 32'h0000_ff00);
    wr(REG_BASE, BASE);
    wr(REG_IRQ_EN, 32'h3fff);
    for (int i = 0; i < 4; i++)
    begin
      mw(32'h200 + 32'(i) * 4, 32'h1111_0000 + 32'(i));
      mw(32'h300 + 32'(i) * 4, 32'h0);
    end
    dsc(5, 32'h20c, 32'h30c, ctl(2'h2, 10'h3, 4'h1));
    wr(REG_EN_SET, 32'h20);
    chan_req_hw <= 14'h20;
    wdone(1);
    chan_req_hw <= '0;
    @(posedge clk);
    chk(32'(irq), 32'h1);
    chk(order[0], 32'h5);
    for (int i = 0; i < 4; i++)
      chk(mr(32'h300 + 32'(i) * 4), 32'h1111_0000 + 32'(i));
    chk(mr(BASE + 32'h58), ctl(2'h2, 10'h0, 4'h1) & 32'hffff_fff8);
    rdc(REG_IRQ_STAT, 32'h20);
    rdc(REG_EN_SET, 32'h0);
    wr(REG_IRQ_CLR, 32'h20);
    rdc(REG_IRQ_STAT, 32'h0);
    chk(32'(irq), 32'h0);
    slow <= 1'b0;
    for (int h = 1; h >= 0; h--)
    begin
      dsc(3, 32'h210, 32'h310, ctl(2'h2, 10'h0, 4'h0));
      dsc(9, 32'h214, 32'h314, ctl(2'h2, 10'h0, 4'h0));
      wr(h ? REG_PRI_SET : REG_PRI_CLR, 32'h200);
      rdc(REG_PRI_SET, h ? 32'h200 : 32'h0);
      wr(REG_EN_SET, 32'h208);
      order.delete();
      wr(REG_SW_REQ, 32'h208);
      wdone(2);
      chk(order[0], h ? 32'h9 : 32'h3);
    end
    // A ping-pong structure keeps its channel enabled and flips to the alternate structure.
    dsc(0, 32'h200, 32'h330, ctl(2'h2, 10'h0, 4'h0) | 32'h2);
    wr(REG_EN_SET, 32'h1);
    order.delete();
    wr(REG_SW_REQ, 32'h1);
    wdone(1);
    chk(mr(32'h330), 32'h1111_0000);
    rdc(REG_ALT, 32'h1);
    rdc(REG_EN_SET, 32'h1);
    rdc(REG_SW_REQ, 32'h0);
    wr(REG_EN_CLR, 32'h1);
    rdc(REG_EN_SET, 32'h0);
    mw(32'h220, 32'h9933_2211);
    mw(32'h320, 32'hffff_ffff);
    dsc(12, 32'h222, 32'h322, ctl(2'h0, 10'h2, 4'h3));
    wr(REG_EN_SET, 32'h1000);
    order.delete();
    slow <= 1'b1;
    chan_req_hw <= 14'h1000;
    wdone(1);
    chan_req_hw <= '0;
    chk(mr(32'h320), 32'hff33_2211);
    wr(REG_IRQ_EN, 32'h0);
    rdc(REG_IRQ_STAT, 32'h1209);
    chk(32'(irq), 32'h0);
    wr(REG_IRQ_EN, 32'h1000);
    @(posedge clk);
    chk(32'(irq), 32'h1);
    rdc(REG_STATUS, 32'h30);
    end_sim();
  end
endmodule // tb_top
